// ===== sxc_ext_regs.sv
// Sequencer extension bank: address limits, timer clears, signature, scratchpads, icon 0
`timescale 1ns/100ps
`include "sxc_cfg.svh"

// How it works
// - Override bit low keeps CRT fetches inside the VGA region.
// - Override low, limit high: CPU reaches all memory, CRT stays limited.
// - Override and limit both high: CPU and CRT reach all memory.
// - Limit low restricts both CPU and CRT; override only touches CRT.
// - Override low with limit high flags icon and cursor mapping update.
// - VGA region is a power-of-two window so addresses wrap inside it.
// - Standby clear bit set: keyboard port read pulses standby timer reset.
// - Backlight clear bit set: keyboard port read pulses backlight timer reset.
// - Low signature register holds signature bits 7:0, reset value 0fh.
// - High signature register holds signature bits 15:8, reset value 0fh.
// - Two BIOS scratch bytes at indices 28h and 29h, reset zero.
// - Thirteen 18-bit palette scratch words, three accesses per word.
// - Icon 0 control resets zero; fields at bits 6,5,4,3,2,1,0.
// - Vertical doubling shows 128 scanlines by repeating lines.
// - Horizontal doubling shows 128 pixels by replicating pixels.
// - Icon blink runs at half the text cursor blink rate.
module sxc_ext_regs #(
  parameter int VGA_AW = 18,
  parameter int MEM_AW = 20,
  parameter int SCR_WORDS = `SXC_PAL_SCR_WORDS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  input wire logic address_limit_bit,
  input wire logic [MEM_AW-1:0] cpu_addr,
  input wire logic [MEM_AW-1:0] crt_addr,
  output logic [MEM_AW-1:0] cpu_addr_eff,
  output logic [MEM_AW-1:0] crt_addr_eff,
  output sxc_pkg::sxc_mem_limit_type mem_limits,
  input wire logic sig_load,
  input wire logic [15:0] sig_value,
  output logic standby_timer_clr,
  output logic backlight_timer_clr,
  input wire logic cursor_blink_tick,
  output sxc_pkg::sxc_icon_ctrl_type icon0_ctrl,
  output logic [7:0] icon0_width,
  output logic [7:0] icon0_height,
  output logic icon0_visible
);

  localparam int SA_W = (SCR_WORDS > 1) ? $clog2(SCR_WORDS) : 1;
  localparam int PW = `SXC_PAL_COMP_W;
  localparam logic [MEM_AW-1:0] VGA_MASK = MEM_AW'((64'd1 << VGA_AW) - 64'd1);

  if (VGA_AW < 1 || VGA_AW >= MEM_AW) begin : g_bad_aw
    $error("sxc_ext_regs: VGA_AW must be below MEM_AW");
  end
  if (SCR_WORDS < 1 || SCR_WORDS > 256 - int'(`SXC_PAL_SCR_BASE)) begin : g_bad_words
    $error("sxc_ext_regs: SCR_WORDS does not fit in the palette index space");
  end

  // Port decode
  logic seq_idx_sel;
  logic seq_data_sel;
  logic pal_data_sel;
  assign seq_idx_sel = (io_addr == `SXC_PORT_SEQ_IDX);
  assign seq_data_sel = (io_addr == `SXC_PORT_SEQ_DATA);
  assign pal_data_sel = (io_addr == `SXC_PORT_PAL_DATA);

  // Register group
  logic [7:0] index_reg, index_next;
  logic [7:0] timer_cfg_reg, timer_cfg_next;
  logic [7:0] sig_low_reg, sig_low_next;
  logic [7:0] sig_high_reg, sig_high_next;
  logic [7:0] scratch_a_reg, scratch_a_next;
  logic [7:0] scratch_b_reg, scratch_b_next;
  sxc_pkg::sxc_icon_ctrl_type icon_reg, icon_next;

  always_comb
  begin
    index_next = index_reg;
    timer_cfg_next = timer_cfg_reg;
    scratch_a_next = scratch_a_reg;
    scratch_b_next = scratch_b_reg;
    icon_next = icon_reg;
    if (io_wr && seq_idx_sel)
    begin
      index_next = io_wdata;
    end
    if (io_wr && seq_data_sel)
    begin
      case (index_reg)
        `SXC_IDX_TIMER_CFG: timer_cfg_next = io_wdata & `SXC_WMASK_TIMER_CFG;
        `SXC_IDX_SCRATCH_A: scratch_a_next = io_wdata;
        `SXC_IDX_SCRATCH_B: scratch_b_next = io_wdata;
        `SXC_IDX_ICON0: icon_next = sxc_pkg::sxc_icon_ctrl_type'(io_wdata & `SXC_WMASK_ICON0);
        default: index_next = index_next;
      endcase
    end
    sig_low_next = sig_load ? sig_value[7:0] : sig_low_reg;
    sig_high_next = sig_load ? sig_value[15:8] : sig_high_reg;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      index_reg <= `SXC_RST_INDEX;
      timer_cfg_reg <= `SXC_RST_TIMER_CFG;
      sig_low_reg <= `SXC_RST_SIG_LOW;
      sig_high_reg <= `SXC_RST_SIG_HIGH;
      scratch_a_reg <= `SXC_RST_SCRATCH;
      scratch_b_reg <= `SXC_RST_SCRATCH;
      icon_reg <= sxc_pkg::sxc_icon_ctrl_type'(`SXC_RST_ICON0);
    end
    else
    begin
      index_reg <= index_next;
      timer_cfg_reg <= timer_cfg_next;
      sig_low_reg <= sig_low_next;
      sig_high_reg <= sig_high_next;
      scratch_a_reg <= scratch_a_next;
      scratch_b_reg <= scratch_b_next;
      icon_reg <= icon_next;
    end
  end

  // Palette scratchpad group
  logic [7:0] pal_widx_reg, pal_widx_next;
  logic [7:0] pal_ridx_reg, pal_ridx_next;
  sxc_pkg::sxc_comp_type wcomp_reg, wcomp_next;
  sxc_pkg::sxc_comp_type rcomp_reg, rcomp_next;
  logic [2*PW-1:0] hold_reg, hold_next;
  logic [7:0] widx_off;
  logic [7:0] ridx_off;
  logic widx_hit;
  logic ridx_hit;
  logic mem_wr_en;
  logic mem_rd_en;
  logic [3*PW-1:0] mem_rdata;

  assign widx_off = pal_widx_reg - `SXC_PAL_SCR_BASE;
  assign ridx_off = pal_ridx_reg - `SXC_PAL_SCR_BASE;
  assign widx_hit = (pal_widx_reg >= `SXC_PAL_SCR_BASE) && (int'(widx_off) < SCR_WORDS);
  assign ridx_hit = (pal_ridx_reg >= `SXC_PAL_SCR_BASE) && (int'(ridx_off) < SCR_WORDS);

  always_comb
  begin
    pal_widx_next = pal_widx_reg;
    pal_ridx_next = pal_ridx_reg;
    wcomp_next = wcomp_reg;
    rcomp_next = rcomp_reg;
    hold_next = hold_reg;
    mem_wr_en = 1'b0;
    mem_rd_en = 1'b0;
    if (io_wr && (io_addr == `SXC_PORT_PAL_WIDX))
    begin
      pal_widx_next = io_wdata;
      wcomp_next = sxc_pkg::SXC_COMP_RED;
    end
    if (io_wr && (io_addr == `SXC_PORT_PAL_RIDX))
    begin
      pal_ridx_next = io_wdata;
      rcomp_next = sxc_pkg::SXC_COMP_RED;
    end
    if (io_wr && pal_data_sel)
    begin
      case (wcomp_reg)
        sxc_pkg::SXC_COMP_RED:
        begin
          hold_next[2*PW-1:PW] = io_wdata[PW-1:0];
          wcomp_next = sxc_pkg::SXC_COMP_GREEN;
        end
        sxc_pkg::SXC_COMP_GREEN:
        begin
          hold_next[PW-1:0] = io_wdata[PW-1:0];
          wcomp_next = sxc_pkg::SXC_COMP_BLUE;
        end
        sxc_pkg::SXC_COMP_BLUE:
        begin
          mem_wr_en = widx_hit;
          pal_widx_next = pal_widx_reg + 8'h01;
          wcomp_next = sxc_pkg::SXC_COMP_RED;
        end
        default: wcomp_next = sxc_pkg::SXC_COMP_RED;
      endcase
    end
    if (io_rd && pal_data_sel)
    begin
      mem_rd_en = ridx_hit;
      case (rcomp_reg)
        sxc_pkg::SXC_COMP_RED: rcomp_next = sxc_pkg::SXC_COMP_GREEN;
        sxc_pkg::SXC_COMP_GREEN: rcomp_next = sxc_pkg::SXC_COMP_BLUE;
        sxc_pkg::SXC_COMP_BLUE:
        begin
          pal_ridx_next = pal_ridx_reg + 8'h01;
          rcomp_next = sxc_pkg::SXC_COMP_RED;
        end
        default: rcomp_next = sxc_pkg::SXC_COMP_RED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pal_widx_reg <= 8'h00;
      pal_ridx_reg <= 8'h00;
      wcomp_reg <= sxc_pkg::SXC_COMP_RED;
      rcomp_reg <= sxc_pkg::SXC_COMP_RED;
      hold_reg <= '0;
    end
    else
    begin
      pal_widx_reg <= pal_widx_next;
      pal_ridx_reg <= pal_ridx_next;
      wcomp_reg <= wcomp_next;
      rcomp_reg <= rcomp_next;
      hold_reg <= hold_next;
    end
  end

  sxc_scratch_mem #(
    .DEPTH(SCR_WORDS),
    .WIDTH(3 * PW),
    .AW(SA_W)
  ) u_scratch_mem (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(mem_wr_en),
    .wr_addr(widx_off[SA_W-1:0]),
    .wr_data({hold_reg, io_wdata[PW-1:0]}),
    .rd_en(mem_rd_en),
    .rd_addr(ridx_off[SA_W-1:0]),
    .rd_data(mem_rdata)
  );

  // Read path: two stages so palette words and plain registers share one latency
  logic rd_pend_reg, rd_pend_next;
  logic rd_pal_reg, rd_pal_next;
  logic rd_hit_reg, rd_hit_next;
  sxc_pkg::sxc_comp_type rd_comp_reg, rd_comp_next;
  logic [7:0] rd_val_reg, rd_val_next;
  logic [7:0] io_rdata_reg, io_rdata_next;
  logic io_rvalid_reg;
  logic [7:0] idx_val;

  always_comb
  begin
    case (index_reg)
      `SXC_IDX_TIMER_CFG: idx_val = timer_cfg_reg;
      // Signature bytes, factory test use
      `SXC_IDX_SIG_LOW: idx_val = sig_low_reg;
      `SXC_IDX_SIG_HIGH: idx_val = sig_high_reg;
      `SXC_IDX_SCRATCH_A: idx_val = scratch_a_reg;
      `SXC_IDX_SCRATCH_B: idx_val = scratch_b_reg;
      `SXC_IDX_ICON0: idx_val = icon_reg;
      default: idx_val = 8'h00;
    endcase
    rd_pend_next = io_rd && (seq_idx_sel || seq_data_sel || pal_data_sel
      || (io_addr == `SXC_PORT_PAL_WIDX) || (io_addr == `SXC_PORT_PAL_RIDX));
    rd_pal_next = pal_data_sel;
    rd_hit_next = ridx_hit;
    rd_comp_next = rcomp_reg;
    if (seq_idx_sel)
    begin
      rd_val_next = index_reg;
    end
    else if (seq_data_sel)
    begin
      rd_val_next = idx_val;
    end
    else if (io_addr == `SXC_PORT_PAL_WIDX)
    begin
      rd_val_next = pal_widx_reg;
    end
    else
    begin
      rd_val_next = 8'h00;
    end
    io_rdata_next = io_rdata_reg;
    if (rd_pend_reg)
    begin
      if (!rd_pal_reg)
      begin
        io_rdata_next = rd_val_reg;
      end
      else if (!rd_hit_reg)
      begin
        io_rdata_next = 8'h00;
      end
      else
      begin
        case (rd_comp_reg)
          sxc_pkg::SXC_COMP_RED: io_rdata_next = {2'b00, mem_rdata[3*PW-1:2*PW]};
          sxc_pkg::SXC_COMP_GREEN: io_rdata_next = {2'b00, mem_rdata[2*PW-1:PW]};
          default: io_rdata_next = {2'b00, mem_rdata[PW-1:0]};
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_pend_reg <= 1'b0;
      rd_pal_reg <= 1'b0;
      rd_hit_reg <= 1'b0;
      rd_comp_reg <= sxc_pkg::SXC_COMP_RED;
      rd_val_reg <= 8'h00;
      io_rdata_reg <= 8'h00;
      io_rvalid_reg <= 1'b0;
    end
    else
    begin
      rd_pend_reg <= rd_pend_next;
      rd_pal_reg <= rd_pal_next;
      rd_hit_reg <= rd_hit_next;
      rd_comp_reg <= rd_comp_next;
      rd_val_reg <= rd_val_next;
      io_rdata_reg <= io_rdata_next;
      io_rvalid_reg <= rd_pend_reg;
    end
  end

  // Output group
  sxc_pkg::sxc_mem_limit_type lim_reg, lim_next;
  logic [MEM_AW-1:0] cpu_eff_reg, cpu_eff_next;
  logic [MEM_AW-1:0] crt_eff_reg, crt_eff_next;
  logic standby_clr_reg, standby_clr_next;
  logic backlight_clr_reg, backlight_clr_next;
  logic blink_div_reg, blink_div_next;
  logic blink_phase_reg, blink_phase_next;
  logic visible_reg, visible_next;
  logic [7:0] width_reg, width_next;
  logic [7:0] height_reg, height_next;
  logic kbd_rd;
  logic ovr;

  assign kbd_rd = io_rd && (io_addr == `SXC_PORT_KBD);
  assign ovr = timer_cfg_reg[`SXC_BIT_CRT_OVERRIDE];

  always_comb
  begin
    lim_next.cpu_ext = address_limit_bit;
    lim_next.crt_ext = address_limit_bit & ovr;
    lim_next.map_update = address_limit_bit & ~ovr;
    cpu_eff_next = lim_next.cpu_ext ? cpu_addr : (cpu_addr & VGA_MASK);
    crt_eff_next = lim_next.crt_ext ? crt_addr : (crt_addr & VGA_MASK);
    standby_clr_next = kbd_rd & timer_cfg_reg[`SXC_BIT_STANDBY_CLR];
    backlight_clr_next = kbd_rd & timer_cfg_reg[`SXC_BIT_BACKLIGHT_CLR];
    // phase flips every second cursor tick
    blink_div_next = blink_div_reg ^ cursor_blink_tick;
    blink_phase_next = blink_phase_reg ^ (cursor_blink_tick & blink_div_reg);
    visible_next = icon_reg.disp_en & (~icon_reg.blink_en | blink_phase_reg);
    width_next = icon_reg.hdouble ? `SXC_ICON_SIZE_DOUBLE : `SXC_ICON_SIZE_NORMAL;
    height_next = icon_reg.vdouble ? `SXC_ICON_SIZE_DOUBLE : `SXC_ICON_SIZE_NORMAL;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lim_reg <= '0;
      cpu_eff_reg <= '0;
      crt_eff_reg <= '0;
      standby_clr_reg <= 1'b0;
      backlight_clr_reg <= 1'b0;
      blink_div_reg <= 1'b0;
      blink_phase_reg <= 1'b0;
      visible_reg <= 1'b0;
      width_reg <= `SXC_ICON_SIZE_NORMAL;
      height_reg <= `SXC_ICON_SIZE_NORMAL;
    end
    else
    begin
      lim_reg <= lim_next;
      cpu_eff_reg <= cpu_eff_next;
      crt_eff_reg <= crt_eff_next;
      standby_clr_reg <= standby_clr_next;
      backlight_clr_reg <= backlight_clr_next;
      blink_div_reg <= blink_div_next;
      blink_phase_reg <= blink_phase_next;
      visible_reg <= visible_next;
      width_reg <= width_next;
      height_reg <= height_next;
    end
  end

  assign io_rdata = io_rdata_reg;
  assign io_rvalid = io_rvalid_reg;
  assign mem_limits = lim_reg;
  assign cpu_addr_eff = cpu_eff_reg;
  assign crt_addr_eff = crt_eff_reg;
  assign standby_timer_clr = standby_clr_reg;
  assign backlight_timer_clr = backlight_clr_reg;
  assign icon0_ctrl = icon_reg;
  assign icon0_width = width_reg;
  assign icon0_height = height_reg;
  assign icon0_visible = visible_reg;

endmodule : sxc_ext_regs

// ===== sxc_cfg.svh
// Register indices, port addresses, field positions and reset values for the extension bank
`ifndef SXC_CFG_SVH
`define SXC_CFG_SVH

`define SXC_PORT_KBD 16'h0060
`define SXC_PORT_SEQ_IDX 16'h03c4
`define SXC_PORT_SEQ_DATA 16'h03c5
`define SXC_PORT_PAL_RIDX 16'h03c7
`define SXC_PORT_PAL_WIDX 16'h03c8
`define SXC_PORT_PAL_DATA 16'h03c9

`define SXC_IDX_TIMER_CFG 8'h25
`define SXC_IDX_SIG_LOW 8'h26
`define SXC_IDX_SIG_HIGH 8'h27
`define SXC_IDX_SCRATCH_A 8'h28
`define SXC_IDX_SCRATCH_B 8'h29
`define SXC_IDX_ICON0 8'h2a

`define SXC_BIT_BACKLIGHT_CLR 0
`define SXC_BIT_STANDBY_CLR 1
`define SXC_BIT_CRT_OVERRIDE 2

`define SXC_RST_TIMER_CFG 8'h1e
`define SXC_RST_SIG_LOW 8'h0f
`define SXC_RST_SIG_HIGH 8'h0f
`define SXC_RST_SCRATCH 8'h00
`define SXC_RST_ICON0 8'h00
`define SXC_RST_INDEX 8'h00
`define SXC_WMASK_TIMER_CFG 8'h7f
`define SXC_WMASK_ICON0 8'h7f

`define SXC_PAL_SCR_BASE 8'hf3
`define SXC_PAL_SCR_WORDS 13
`define SXC_PAL_COMP_W 6

`define SXC_ICON_SIZE_NORMAL 8'h40
`define SXC_ICON_SIZE_DOUBLE 8'h80

`endif

// ===== sxc_pkg.sv
// Types shared by the sequencer extension register bank
package sxc_pkg;

  typedef struct packed {
    logic reserved;
    logic fine_hpos3;
    logic map_sel;
    logic vdouble;
    logic hdouble;
    logic blink_en;
    logic mode_sel;
    logic disp_en;
  } sxc_icon_ctrl_type;

  typedef struct packed {
    logic cpu_ext;
    logic crt_ext;
    logic map_update;
  } sxc_mem_limit_type;

  typedef enum logic [2:0] {
    SXC_COMP_RED = 3'b001,
    SXC_COMP_GREEN = 3'b010,
    SXC_COMP_BLUE = 3'b100
  } sxc_comp_type;

endpackage : sxc_pkg

// ===== sxc_scratch_mem.sv
// Palette scratchpad word store with registered read data
`timescale 1ns/100ps

module sxc_scratch_mem #(
  parameter int DEPTH = 13,
  parameter int WIDTH = 18,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_array [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;
  logic [WIDTH-1:0] rd_data_next;

  if ((1 << AW) < DEPTH) begin : g_bad_aw
    $error("sxc_scratch_mem: AW too small for DEPTH");
  end

  always_comb
  begin
    rd_data_next = rd_data_reg;
    if (rd_en && (int'(rd_addr) < DEPTH))
    begin
      rd_data_next = mem_array[rd_addr];
    end
  end

  // Array itself has no reset; contents are undefined until written
  always_ff @(posedge clk)
  begin
    if (wr_en && (int'(wr_addr) < DEPTH))
    begin
      mem_array[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_reg <= '0;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;

endmodule : sxc_scratch_mem

// ===== sxc_ext_regs_properties.sv
// Port-level assertions for the sequencer extension bank
`timescale 1ns/100ps
`include "sxc_cfg.svh"

module sxc_ext_regs_properties #(
  parameter int VGA_AW = 18,
  parameter int MEM_AW = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic io_rvalid,
  input wire logic address_limit_bit,
  input wire logic [MEM_AW-1:0] cpu_addr,
  input wire logic [MEM_AW-1:0] crt_addr,
  input wire logic [MEM_AW-1:0] cpu_addr_eff,
  input wire logic [MEM_AW-1:0] crt_addr_eff,
  input wire sxc_pkg::sxc_mem_limit_type mem_limits,
  input wire logic standby_timer_clr,
  input wire logic backlight_timer_clr,
  input wire sxc_pkg::sxc_icon_ctrl_type icon0_ctrl,
  input wire logic [7:0] icon0_width,
  input wire logic [7:0] icon0_height,
  input wire logic icon0_visible
);
  logic [7:0] idx_reg;
  logic [7:0] idx_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] cfg_q_reg;
  logic [MEM_AW-1:0] vga_mask;

  // Shadow of the config byte, so limit checks know the override
  assign vga_mask = {{(MEM_AW-VGA_AW){1'b0}}, {VGA_AW{1'b1}}};
  always_comb
  begin
    idx_next = idx_reg;
    cfg_next = cfg_reg;
    if (io_wr && io_addr == `SXC_PORT_SEQ_IDX)
      idx_next = io_wdata;
    if (io_wr && io_addr == `SXC_PORT_SEQ_DATA && idx_reg == `SXC_IDX_TIMER_CFG)
      cfg_next = io_wdata;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_reg <= `SXC_RST_INDEX;
      cfg_reg <= `SXC_RST_TIMER_CFG;
      cfg_q_reg <= `SXC_RST_TIMER_CFG;
    end
    else
    begin
      idx_reg <= idx_next;
      cfg_reg <= cfg_next;
      cfg_q_reg <= cfg_reg;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_io_read;
    io_rd && (io_addr inside {`SXC_PORT_SEQ_IDX, `SXC_PORT_SEQ_DATA, `SXC_PORT_PAL_RIDX,
      `SXC_PORT_PAL_WIDX, `SXC_PORT_PAL_DATA});
  endsequence
  sequence seq_kbd_read;
    io_rd && io_addr == `SXC_PORT_KBD;
  endsequence

  AST_READ_ANSWER: assert property (seq_io_read |-> ##2 io_rvalid)
    else $error("read answer not two cycles later");
  // Exact cause: only a read of a bank port two cycles back may answer
  AST_RVALID_CAUSE: assert property (io_rvalid |-> $past(io_rd && (io_addr inside
    {`SXC_PORT_SEQ_IDX, `SXC_PORT_SEQ_DATA, `SXC_PORT_PAL_RIDX, `SXC_PORT_PAL_WIDX,
    `SXC_PORT_PAL_DATA}), 2))
    else $error("read answer without a read");
  AST_STANDBY_CLR: assert property (seq_kbd_read |=> standby_timer_clr == cfg_q_reg[1])
    else $error("standby clear wrong after keyboard read");
  AST_BACKLIGHT_CLR: assert property (backlight_timer_clr |-> $past(io_rd && io_addr == 16'h0060 && cfg_reg[0]))
    else $error("backlight clear without cause");
  AST_CPU_PATH: assert property ($past(rst_n) |-> cpu_addr_eff == ($past(address_limit_bit) ? $past(cpu_addr) : $past(cpu_addr) & vga_mask))
    else $error("cpu address limit wrong");
  AST_CRT_PATH: assert property (cfg_reg == cfg_q_reg |-> crt_addr_eff == (($past(address_limit_bit) && cfg_reg[2]) ? $past(crt_addr) : $past(crt_addr) & vga_mask))
    else $error("crt address limit wrong");
  AST_LIMIT_FLAGS: assert property (cfg_reg == cfg_q_reg |-> mem_limits == {$past(address_limit_bit), $past(address_limit_bit) & cfg_reg[2], $past(address_limit_bit) & ~cfg_reg[2]})
    else $error("limit flags wrong");
  AST_ICON_SIZE: assert property (icon0_width == ($past(icon0_ctrl.hdouble) ? 8'h80 : 8'h40) && icon0_height == ($past(icon0_ctrl.vdouble) ? 8'h80 : 8'h40))
    else $error("icon size wrong");
  AST_ICON_HIDDEN: assert property (!icon0_ctrl.disp_en |=> !icon0_visible)
    else $error("disabled icon visible");
  AST_ICON_STEADY: assert property ((icon0_ctrl.disp_en && !icon0_ctrl.blink_en) [*2] |=> icon0_visible)
    else $error("steady icon hidden");
endmodule : sxc_ext_regs_properties

// ===== sxc_ext_regs_test.sv
// Self-checking bench for the sequencer extension bank
`timescale 1ns/100ps
`include "sxc_cfg.svh"

module sxc_ext_regs_test;
  localparam int MAW = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic io_rvalid;
  logic address_limit_bit = 1'b0;
  logic [MAW-1:0] cpu_addr = '0;
  logic [MAW-1:0] crt_addr = '0;
  logic [MAW-1:0] cpu_addr_eff;
  logic [MAW-1:0] crt_addr_eff;
  sxc_pkg::sxc_mem_limit_type mem_limits;
  logic sig_load = 1'b0;
  logic [15:0] sig_value = 16'h0000;
  logic standby_timer_clr;
  logic backlight_timer_clr;
  logic cursor_blink_tick = 1'b0;
  sxc_pkg::sxc_icon_ctrl_type icon0_ctrl;
  logic [7:0] icon0_width;
  logic [7:0] icon0_height;
  logic icon0_visible;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int regm [int];
  int pal [13];
  int a;
  int b;
  int lim;
  int ovr;
  logic vis0;

  always #12.5 clk = ~clk;

  sxc_ext_regs i_dut (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .address_limit_bit(address_limit_bit), .cpu_addr(cpu_addr), .crt_addr(crt_addr),
    .cpu_addr_eff(cpu_addr_eff), .crt_addr_eff(crt_addr_eff), .mem_limits(mem_limits),
    .sig_load(sig_load), .sig_value(sig_value), .standby_timer_clr(standby_timer_clr),
    .backlight_timer_clr(backlight_timer_clr), .cursor_blink_tick(cursor_blink_tick),
    .icon0_ctrl(icon0_ctrl), .icon0_width(icon0_width), .icon0_height(icon0_height),
    .icon0_visible(icon0_visible));

  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic io_write(input logic [15:0] ad, input logic [7:0] d);
    @(negedge clk);
    io_addr = ad;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask : io_write

  task automatic io_read(input logic [15:0] ad, input int exp);
    int n;
    @(negedge clk);
    io_addr = ad;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    n = 0;
    while (io_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    chk(io_rvalid, 1, "read answer");
    chk(io_rdata, exp, "read data");
  endtask : io_read

  // Model applies the write masks; signature bytes ignore writes
  task automatic reg_wr(input int i, input int d);
    io_write(`SXC_PORT_SEQ_IDX, 8'(i));
    io_write(`SXC_PORT_SEQ_DATA, 8'(d));
    if (i == 'h25 || i == 'h2a)
      regm[i] = d & 'h7f;
    else if (i == 'h28 || i == 'h29)
      regm[i] = d & 'hff;
  endtask : reg_wr

  task automatic reg_rd(input int i);
    io_write(`SXC_PORT_SEQ_IDX, 8'(i));
    io_read(`SXC_PORT_SEQ_DATA, regm.exists(i) ? regm[i] : 0);
  endtask : reg_rd

  task automatic tick;
    @(negedge clk);
    cursor_blink_tick = 1'b1;
    @(negedge clk);
    cursor_blink_tick = 1'b0;
  endtask : tick

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      failures++;
      $display("[FAIL] %0t run too long", $time);
      conclude();
    end
  end

  initial
  begin
    regm['h25] = `SXC_RST_TIMER_CFG;
    regm['h26] = `SXC_RST_SIG_LOW;
    regm['h27] = `SXC_RST_SIG_HIGH;
    regm['h28] = 0;
    regm['h29] = 0;
    regm['h2a] = 0;
    a = $urandom(16);
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 'h25; i <= 'h2b; i++) reg_rd(i);
    for (int i = 'h25; i <= 'h2b; i++) reg_wr(i, $urandom % 256);
    for (int i = 'h25; i <= 'h2b; i++) reg_rd(i);
    b = $urandom % 65536;
    @(negedge clk);
    sig_value = 16'(b);
    sig_load = 1'b1;
    @(negedge clk);
    sig_load = 1'b0;
    regm['h26] = b % 256;
    regm['h27] = b / 256;
    reg_rd('h26);
    reg_rd('h27);
    io_read(`SXC_PORT_SEQ_IDX, 'h27);
    for (int k = 0; k < 8; k++)
    begin
      ovr = k % 2;
      lim = (k / 2) % 2;
      reg_wr('h25, ovr * 4);
      a = $urandom % (1 << MAW);
      b = $urandom % (1 << MAW);
      @(negedge clk);
      address_limit_bit = lim[0];
      cpu_addr = MAW'(a);
      crt_addr = MAW'(b);
      @(negedge clk);
      chk(cpu_addr_eff, lim ? a : a % (1 << 18), "cpu addr");
      chk(crt_addr_eff, (lim && ovr) ? b : b % (1 << 18), "crt addr");
      chk(mem_limits, lim * 4 + lim * ovr * 2 + lim * (1 - ovr), "limit flags");
    end
    for (int k = 0; k < 4; k++)
    begin
      reg_wr('h25, k);
      @(negedge clk);
      io_addr = `SXC_PORT_KBD;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      chk(standby_timer_clr, k / 2, "standby clear");
      chk(backlight_timer_clr, k % 2, "backlight clear");
      @(negedge clk);
      chk({standby_timer_clr, backlight_timer_clr}, 0, "clear pulse");
    end
    reg_wr('h2a, 'h18);
    @(negedge clk);
    chk(icon0_ctrl, 'h18, "icon fields");
    chk({icon0_width, icon0_height}, 'h8080, "icon size");
    reg_wr('h2a, 'h05);
    repeat (2) @(negedge clk);
    vis0 = icon0_visible;
    repeat (2) tick();
    repeat (2) @(negedge clk);
    chk(icon0_visible, !vis0, "blink toggle");
    tick();
    repeat (2) @(negedge clk);
    chk(icon0_visible, !vis0, "blink half rate");
    reg_wr('h2a, 'h01);
    repeat (2) @(negedge clk);
    chk(icon0_visible, 1, "steady icon");
    chk({icon0_width, icon0_height}, 'h4040, "icon normal size");
    // Thirteen words, three component accesses each
    io_write(`SXC_PORT_PAL_WIDX, `SXC_PAL_SCR_BASE);
    io_read(`SXC_PORT_PAL_WIDX, `SXC_PAL_SCR_BASE);
    for (int w = 0; w < 13; w++)
    begin
      pal[w] = $urandom % (1 << 18);
      for (int c = 2; c >= 0; c--) io_write(`SXC_PORT_PAL_DATA, 8'((pal[w] >> (6 * c)) % 64));
    end
    io_write(`SXC_PORT_PAL_RIDX, `SXC_PAL_SCR_BASE);
    io_read(`SXC_PORT_PAL_RIDX, 0);
    for (int w = 0; w < 13; w++)
      for (int c = 2; c >= 0; c--) io_read(`SXC_PORT_PAL_DATA, (pal[w] >> (6 * c)) % 64);
    io_write(`SXC_PORT_PAL_RIDX, 8'h10);
    io_read(`SXC_PORT_PAL_DATA, 0);
    conclude();
  end
endmodule : sxc_ext_regs_test

bind sxc_ext_regs sxc_ext_regs_properties #(.VGA_AW(VGA_AW), .MEM_AW(MEM_AW)) i_props (
  .clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rvalid(io_rvalid), .address_limit_bit(address_limit_bit),
  .cpu_addr(cpu_addr), .crt_addr(crt_addr), .cpu_addr_eff(cpu_addr_eff),
  .crt_addr_eff(crt_addr_eff), .mem_limits(mem_limits), .standby_timer_clr(standby_timer_clr),
  .backlight_timer_clr(backlight_timer_clr), .icon0_ctrl(icon0_ctrl),
  .icon0_width(icon0_width), .icon0_height(icon0_height), .icon0_visible(icon0_visible));
